// [src/dtd_timer.sv]
// Dual 8-bit timer/counter with register port and source clock selection
`timescale 1ns/100ps
`include "dtd_cfg.svh"
// Summary of operation
// - Two independent 8-bit units, three modes each
// - Timer counts internal clock, match clears, interrupts
// - Event mode counts falling edges of input
// - Compare value takes effect immediately
// - Divider match toggles flip-flop, clears, interrupts
// - Divider output is fifty percent square wave
// - Output pin is inverse of flip-flop
// - Flip-flop loadable by control bit, reset zero
// - Stopped divider holds level; change separately
// - Run bit three, flip-flop bit seven
// - Mode field codes select timer or divider
// - Clock field codes select prescaler taps
module dtd_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`DTD_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic low_freq_clock,
    input wire logic slow_prescale_select,
    input wire logic [1:0] event_input_pin,
    output logic [1:0] match_irq,
    output logic [1:0] divider_output_pin
);
    logic [7:0] ctrl_r [2];
    logic [7:0] ctrl_nxt [2];
    logic [7:0] cmp_r [2];
    logic [7:0] cmp_nxt [2];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [`DTD_PRE_W-1:0] pre_r;
    logic [`DTD_PRE_W-1:0] pre_nxt;
    logic [`DTD_LOW_DIV_W-1:0] ldiv_r;
    logic [`DTD_LOW_DIV_W-1:0] ldiv_nxt;
    logic low_q_r;
    logic low_q_nxt;
    logic [1:0] ev_q_r;
    logic [1:0] ev_q_nxt;
    logic [`DTD_PRE_W-1:0] pre_rise;
    logic low_rise;
    logic low8_rise;
    logic [1:0] tick;
    logic [1:0] ff_wr;
    logic [7:0] cnt [2];
    logic [1:0] match;

    // Decode the control offset of a unit
    function automatic logic [`DTD_ADDR_W-1:0] ctrl_off(input int u);
        return (u == 0) ? `DTD_OFF_CTRL0 : `DTD_OFF_CTRL1;
    endfunction

    function automatic logic [`DTD_ADDR_W-1:0] cmp_off(input int u);
        return (u == 0) ? `DTD_OFF_CMP0 : `DTD_OFF_CMP1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Prescaler of the high frequency clock; clk stands in for it
    always_comb begin
        pre_nxt = pre_r + `DTD_PRE_W'(1);
        pre_rise = pre_nxt & ~pre_r;
        low_q_nxt = low_freq_clock;
        low_rise = low_freq_clock & ~low_q_r;
        ldiv_nxt = low_rise ? ldiv_r + `DTD_LOW_DIV_W'(1) : ldiv_r;
        low8_rise = low_rise && (ldiv_r == {`DTD_LOW_DIV_W{1'b1}});
        ev_q_nxt = event_input_pin;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= '0;
            ldiv_r <= '0;
            low_q_r <= 1'b0;
            ev_q_r <= 2'h3;
        end else begin
            pre_r <= pre_nxt;
            ldiv_r <= ldiv_nxt;
            low_q_r <= low_q_nxt;
            ev_q_r <= ev_q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection per unit
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_unit
            logic [2:0] ck;
            logic [2:0] md;
            logic src;
            assign ck = ctrl_r[g][`DTD_CLK_LSB+2:`DTD_CLK_LSB];
            assign md = ctrl_r[g][`DTD_MODE_LSB+2:`DTD_MODE_LSB];
            always_comb begin
                case (ck)
                    `DTD_CK_SLOWEST: src = slow_prescale_select ?
                        low8_rise : pre_rise[`DTD_TAP_SLOW];
                    `DTD_CK_D7: src = pre_rise[`DTD_TAP_D7];
                    `DTD_CK_D5: src = pre_rise[`DTD_TAP_D5];
                    `DTD_CK_D3: src = pre_rise[`DTD_TAP_D3];
                    `DTD_CK_LOW: src = low_rise;
                    `DTD_CK_D1: src = pre_rise[`DTD_TAP_D1];
                    `DTD_CK_FULL: src = 1'b1;
                    default: src = 1'b0;
                endcase
                // Timer code with no internal tap chosen counts pin edges;
                // the pin is assumed slow enough to need no filter
                if (md == `DTD_MODE_TIMER && ck == `DTD_CK_PIN) begin
                    tick[g] = ev_q_r[g] & ~event_input_pin[g];
                end else if (md == `DTD_MODE_TIMER || md == `DTD_MODE_DIV) begin
                    tick[g] = src;
                end else begin
                    tick[g] = 1'b0;
                end
            end

            dtd_unit u_unit (
                .clk(clk),
                .rst_b(rst_b),
                .tick(tick[g]),
                .ctrl(ctrl_r[g]),
                .cmp(cmp_r[g]),
                .ff_wr(ff_wr[g]),
                .ff_val(wdata[`DTD_FF_BIT]),
                .count(cnt[g]),
                .match(match[g]),
                .divider_output_pin(divider_output_pin[g])
            );
        end
    endgenerate

    assign match_irq = match;

    ////////////////////////////////////////////////////////////////////////
    // Register port
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            ctrl_nxt[u] = ctrl_r[u];
            cmp_nxt[u] = cmp_r[u];
            ff_wr[u] = 1'b0;
            if (wr && addr == ctrl_off(u)) begin
                ctrl_nxt[u] = wdata;
                // Flip-flop loads while the unit was stopped, or keeps running
                // with bit seven unchanged; never on the stopping write
                ff_wr[u] = !ctrl_r[u][`DTD_RUN_BIT] ||
                           (wdata[`DTD_FF_BIT] == ctrl_r[u][`DTD_FF_BIT]);
                ff_wr[u] = ff_wr[u] && !(ctrl_r[u][`DTD_RUN_BIT] &&
                           !wdata[`DTD_RUN_BIT]);
            end
            if (wr && addr == cmp_off(u)) begin
                cmp_nxt[u] = wdata;
            end
        end
        rdata_nxt = 8'h00;
        if (rd) begin
            case (addr)
                `DTD_OFF_CTRL0: rdata_nxt = ctrl_r[0];
                `DTD_OFF_CMP0: rdata_nxt = cmp_r[0];
                `DTD_OFF_CNT0: rdata_nxt = cnt[0];
                `DTD_OFF_CTRL1: rdata_nxt = ctrl_r[1];
                `DTD_OFF_CMP1: rdata_nxt = cmp_r[1];
                `DTD_OFF_CNT1: rdata_nxt = cnt[1];
                `DTD_OFF_STATUS: rdata_nxt = {4'h0, ~divider_output_pin,
                                              ctrl_r[1][`DTD_RUN_BIT],
                                              ctrl_r[0][`DTD_RUN_BIT]};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int u = 0; u < 2; u++) begin
                ctrl_r[u] <= `DTD_CTRL_RST;
                cmp_r[u] <= `DTD_CMP_RST;
            end
            rdata_r <= 8'h00;
        end else begin
            for (int u = 0; u < 2; u++) begin
                ctrl_r[u] <= ctrl_nxt[u];
                cmp_r[u] <= cmp_nxt[u];
            end
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
endmodule

// [src/dtd_cfg.svh]
// Register offsets, field positions and timing constants of the dual timer
`ifndef DTD_CFG_SVH
`define DTD_CFG_SVH

`define DTD_DATA_W 8
`define DTD_ADDR_W 4
// Register offsets, three per unit plus a shared status
`define DTD_OFF_CTRL0 4'h0
`define DTD_OFF_CMP0 4'h1
`define DTD_OFF_CNT0 4'h2
`define DTD_OFF_CTRL1 4'h4
`define DTD_OFF_CMP1 4'h5
`define DTD_OFF_CNT1 4'h6
`define DTD_OFF_STATUS 4'h8
// Control register fields
`define DTD_CLK_LSB 0
`define DTD_RUN_BIT 3
`define DTD_MODE_LSB 4
`define DTD_FF_BIT 7
`define DTD_CTRL_RST 8'h00
`define DTD_CMP_RST 8'hFF
// Mode codes
`define DTD_MODE_TIMER 3'h0
`define DTD_MODE_DIV 3'h1
// Clock select codes
`define DTD_CK_SLOWEST 3'h0
`define DTD_CK_D7 3'h1
`define DTD_CK_D5 3'h2
`define DTD_CK_D3 3'h3
`define DTD_CK_LOW 3'h4
`define DTD_CK_D1 3'h5
`define DTD_CK_FULL 3'h6
// Timer code with this clock code counts event pin edges
`define DTD_CK_PIN 3'h7
// Prescaler taps of the high frequency clock
`define DTD_PRE_W 11
`define DTD_TAP_SLOW 10
`define DTD_TAP_D7 6
`define DTD_TAP_D5 4
`define DTD_TAP_D3 2
`define DTD_TAP_D1 0
// Low frequency clock divided by 2^3
`define DTD_LOW_DIV_W 3

`endif

// [src/dtd_pkg.sv]
// Types shared by the dual timer design
package dtd_pkg;
    typedef enum logic [1:0] {
        DTD_IDLE,
        DTD_RUN
    } dtd_state_type;
endpackage

// [src/dtd_unit.sv]
// One 8-bit timer unit: counter, compare, output flip-flop
`timescale 1ns/100ps
`include "dtd_cfg.svh"
module dtd_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic [7:0] ctrl,
    input wire logic [7:0] cmp,
    input wire logic ff_wr,
    input wire logic ff_val,
    output logic [7:0] count,
    output logic match,
    output logic divider_output_pin
);
    dtd_pkg::dtd_state_type state_r;
    dtd_pkg::dtd_state_type state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic ff_r;
    logic ff_nxt;
    logic match_r;
    logic match_nxt;
    logic run;
    logic is_div;

    assign run = ctrl[`DTD_RUN_BIT];
    assign is_div = ctrl[`DTD_MODE_LSB+2:`DTD_MODE_LSB] == `DTD_MODE_DIV;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ff_nxt = ff_r;
        match_nxt = 1'b0;
        case (state_r)
            dtd_pkg::DTD_IDLE: begin
                cnt_nxt = 8'h00;
                if (run) begin
                    state_nxt = dtd_pkg::DTD_RUN;
                end
            end
            dtd_pkg::DTD_RUN: begin
                if (!run) begin
                    // Counter clears but flip-flop holds its level
                    state_nxt = dtd_pkg::DTD_IDLE;
                    cnt_nxt = 8'h00;
                end else if (tick) begin
                    // Compare read live, no shadow copy
                    if (cnt_r + 8'h01 == cmp) begin
                        cnt_nxt = 8'h00;
                        match_nxt = 1'b1;
                        if (is_div) begin
                            ff_nxt = ~ff_r;
                        end
                    end else begin
                        cnt_nxt = cnt_r + 8'h01;
                    end
                end
            end
            default: begin
                state_nxt = dtd_pkg::DTD_IDLE;
            end
        endcase
        if (ff_wr) begin
            ff_nxt = ff_val;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= dtd_pkg::DTD_IDLE;
            cnt_r <= 8'h00;
            ff_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ff_r <= ff_nxt;
            match_r <= match_nxt;
        end
    end

    assign count = cnt_r;
    assign match = match_r;
    assign divider_output_pin = ~ff_r;
endmodule

// [verification/dtd_partner.sv]
// Partner model: event pulse source and slow clock for the dual timer
`timescale 1ns/100ps
module dtd_partner (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    output logic [1:0] event_input_pin,
    output logic low_freq_clock
);
    logic [3:0] lf_r;
    logic [2:0] ev_r;
    ////////////////////////////////////////////////////////////////////
    // Slow clock runs free with a period of 14 fast cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lf_r <= 4'h0;
            ev_r <= 3'h0;
        end else begin
            lf_r <= (lf_r == 4'hD) ? 4'h0 : lf_r + 4'h1;
            ev_r <= go ? 3'h6 : (ev_r != 3'h0) ? ev_r - 3'h1 : 3'h0;
        end
    end
    assign low_freq_clock = (lf_r < 4'h7);
    // Low for three cycles, then high at least four before the next go
    assign event_input_pin = {2{ev_r < 3'h4}};
endmodule

// [verification/dtd_timer_checker.sv]
// Checker of the dual timer's pins and match pulses
`timescale 1ns/100ps
`include "dtd_cfg.svh"
module dtd_timer_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`DTD_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic low_freq_clock,
    input wire logic slow_prescale_select,
    input wire logic [1:0] event_input_pin,
    input wire logic [1:0] match_irq,
    input wire logic [1:0] divider_output_pin
);
    // Shadow control registers rebuilt from bus writes
    logic [7:0] c0_r, c0_nxt, c1_r, c1_nxt;
    always_comb begin
        c0_nxt = (wr && addr == `DTD_OFF_CTRL0) ? wdata : c0_r;
        c1_nxt = (wr && addr == `DTD_OFF_CTRL1) ? wdata : c1_r;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            c0_r <= `DTD_CTRL_RST;
            c1_r <= `DTD_CTRL_RST;
        end else begin
            c0_r <= c0_nxt;
            c1_r <= c1_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_reset_pin_level: assert property (disable iff (1'b0)
        !rst_b |-> divider_output_pin == 2'h3 && match_irq == 2'h0)
        else $error("pin or match wrong in reset");
    a_div_toggle_u0: assert property (
        match_irq[0] && c0_r[6:4] == `DTD_MODE_DIV && c0_r[3]
        |-> divider_output_pin[0] != $past(divider_output_pin[0]))
        else $error("unit 0 pin did not toggle on match");
    a_div_toggle_u1: assert property (
        match_irq[1] && c1_r[6:4] == `DTD_MODE_DIV && c1_r[3]
        |-> divider_output_pin[1] != $past(divider_output_pin[1]))
        else $error("unit 1 pin did not toggle on match");
    a_timer_pin_still: assert property (
        !$past(wr) && !$past(wr, 2) && c0_r[6:4] == `DTD_MODE_TIMER
        |-> $stable(divider_output_pin[0]))
        else $error("unit 0 pin moved outside divider mode");
    a_stop_quiet_u0: assert property (
        !c0_r[3] && !$past(c0_r[3]) && !$past(c0_r[3], 2) |-> !match_irq[0])
        else $error("unit 0 match while stopped");
    a_stop_quiet_u1: assert property (
        !c1_r[3] && !$past(c1_r[3]) && !$past(c1_r[3], 2) |-> !match_irq[1])
        else $error("unit 1 match while stopped");
    a_ff_load_u0: assert property (
        wr && addr == `DTD_OFF_CTRL0 && !c0_r[3] && !wdata[`DTD_RUN_BIT]
        |-> ##3 divider_output_pin[0] == !$past(wdata[`DTD_FF_BIT], 3))
        else $error("unit 0 pin not loaded from flip-flop bit");
    a_stop_hold_u0: assert property (
        wr && addr == `DTD_OFF_CTRL0 && c0_r[3] && !wdata[`DTD_RUN_BIT]
        |-> ##3 $stable(divider_output_pin[0])[*3])
        else $error("unit 0 pin moved after stop");
endmodule
bind dtd_timer dtd_timer_checker chk_i (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .low_freq_clock(low_freq_clock),
    .slow_prescale_select(slow_prescale_select),
    .event_input_pin(event_input_pin), .match_irq(match_irq),
    .divider_output_pin(divider_output_pin));

// [verification/tb.sv]
// Self-checking bench for the dual 8-bit timer
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sps = 1'b0;
    logic go = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic lfc;
    logic pa;
    logic [1:0] ev, irq, pin;
    logic [31:0] seed = 32'hF17CD7FA;
    int n_fail = 0;
    int num_checks = 0;
    int mc [2] = '{0, 0};
    int ck [8] = '{6, 5, 3, 2, 1, 0, 0, 4};
    int dv [8] = '{1, 2, 8, 32, 128, 2048, 112, 14};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        mc[0] <= mc[0] + irq[0];
        mc[1] <= mc[1] + irq[1];
    end
    dtd_timer dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .low_freq_clock(lfc),
        .slow_prescale_select(sps), .event_input_pin(ev),
        .match_irq(irq), .divider_output_pin(pin));
    dtd_partner src (.clk(clk), .rst_b(rst_b), .go(go),
        .event_input_pin(ev), .low_freq_clock(lfc));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic nap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e,
        input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask
    // Bounded wait for the next match pulse of one unit
    task automatic wait_m(input int u);
        int k;
        int n;
        k = mc[u];
        n = 0;
        while (mc[u] == k) begin
            nap(1);
            n++;
            if (n > 20000) begin
                n_fail++;
                wrap_up();
            end
        end
    endtask
    // First interval is skipped: the prescaler phase makes it short
    task automatic per(input int u, input int e);
        time t0;
        wait_m(u);
        t0 = $time;
        pa = pin[u];
        wait_m(u);
        chk("period", 16'(e), 16'(($time - t0) / 10));
    endtask
    task automatic pulse();
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        nap(10);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        int v;
        // A real falling edge, so the asynchronous reset fires at once
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rreg(4'h0, 8'h00, "ctrl0");
        rreg(4'h1, 8'hFF, "cmp0");
        rreg(4'h3, 8'h00, "unmapped");
        chk("pins", 16'h3, {14'h0, pin});
        wreg(4'hF, 8'hAA);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 1 : (i == 1) ? 255 : seed[6:0] + 1;
            wreg(4'h1, 8'(v));
            wreg(4'h0, 8'h1E);
            per(0, v);
            chk("toggle", {15'h0, ~pa}, {15'h0, pin[0]});
            wreg(4'h0, 8'h16);
            nap(3);
            pa = pin[0];
            nap(5);
            chk("hold", {15'h0, pa}, {15'h0, pin[0]});
            rreg(4'h2, 8'h00, "count0");
            wreg(4'h0, 8'h96);
            nap(3);
            chk("ff one", 16'h0, {15'h0, pin[0]});
            wreg(4'h0, 8'h16);
            nap(3);
            chk("ff zero", 16'h1, {15'h0, pin[0]});
        end
        // Odd entries run unit 1 as a divider, even ones as a timer
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = seed[1:0] + 1;
            @(posedge clk);
            sps <= (i == 6);
            wreg(4'h5, 8'(v));
            wreg(4'h4, {3'h0, 1'(i), 1'b1, 3'(ck[i])});
            if (i == 5) rreg(4'h8, 8'h02, "status");
            per(1, v * dv[i]);
            // Stopping write keeps mode, clock and flip-flop fields
            wreg(4'h4, {3'h0, 1'(i), 1'b0, 3'(ck[i])});
            rreg(4'h6, 8'h00, "count1");
        end
        wreg(4'h1, 8'h03);
        wreg(4'h0, 8'h0F);
        v = mc[0];
        repeat (2) pulse();
        rreg(4'h2, 8'h02, "events");
        pulse();
        chk("event irq", 16'h1, 16'(mc[0] - v));
        rreg(4'h2, 8'h00, "events");
        // Codes 010 and above never tick here
        v = mc[1];
        wreg(4'h4, 8'h2E);
        nap(20);
        rreg(4'h6, 8'h00, "no tick count");
        chk("no tick irq", 16'h0, 16'(mc[1] - v));
        wreg(4'h4, 8'h26);
        // Stop first, load the flip-flop in a later access
        wreg(4'h0, 8'h07);
        nap(6);
        wreg(4'h0, 8'h96);
        nap(3);
        chk("ff load", 16'h0, {15'h0, pin[0]});
        // Reset with both units stopped clears the flip-flop again
        @(posedge clk);
        rst_b <= 1'b0;
        nap(2);
        chk("reset pins", 16'h3, {14'h0, pin});
        @(posedge clk);
        rst_b <= 1'b1;
        rreg(4'h0, 8'h00, "ctrl0 reset");
        rreg(4'h5, 8'hFF, "cmp1 reset");
        wrap_up();
    end
endmodule
